/* verilog/dtts_pkg.sv */
// Shared constants for the dual target two-wire slave and its master end
// Behaviour
// R1: Upper nibble 1010b selects memory target
// R2: Upper nibble 1101b selects register target, memory untouched
// R3: Device is slave only; master makes clock
// R4: Stop aborts any operation in progress
// R5: Start aborts operation, readies new command
// R6: Power trip aborts transaction in progress
// R7: Bits sampled on clock high; stable otherwise
// R8: Acknowledge slot follows every eighth bit
// R9: Released acknowledge slot ends the operation
// R10: Read continues while master acknowledges
// R11: Bits 2-1 must match select pins
// R12: Slave address bit 0 selects read
// R13: Memory write sends two address bytes
// R14: Reads start at latched current address
// R15: Pointer increments per byte, wraps 7fffh
// R16: No limit on burst length
// R17: Register target one address byte, 00h-18h
// R18: Register address above 18h gets no-acknowledge
// R19: Eight bits then acknowledge, both directions
// R20: Bytes shifted most significant bit first
// R21: Random read uses write then repeated start
// R22: Separate pointers for memory and registers
// R23: Memory write commits after eighth bit
// R24: Bus lines synchronised and filtered first
package dtts_pkg;
  localparam logic [3:0]  MEM_ID      = 4'ha;
  localparam logic [3:0]  REG_ID      = 4'hd;
  localparam logic [14:0] MEM_PTR_RST = 15'h0000;
  localparam logic [7:0]  REG_PTR_RST = 8'h00;
  localparam logic [7:0]  REG_ADDR_MAX = 8'h18;
  localparam int          BIT_COUNT   = 8;
  localparam int          FILT_LEN    = 3;
  localparam int          SYS_MHZ     = 100;
  localparam int          SCL_HALF_NS = 500;
  localparam int          SCL_HALF_CYC = (SCL_HALF_NS * SYS_MHZ) / 1000;
endpackage

/* verilog/dtts_bus_if.sv */
// Two-wire bus between slave and master, with open-drain resolution
`timescale 1ns/1ps
interface dtts_bus_if;
  logic sclOut;
  logic sclOe;
  logic sdaMOut;
  logic sdaMOe;
  logic sdaSOut;
  logic sdaSOe;
  wire  scl;
  wire  sda;
  // Enables are low while driving; released lines pull high
  assign scl = ~(!sclOe && !sclOut);
  assign sda = ~((!sdaMOe && !sdaMOut) || (!sdaSOe && !sdaSOut));
  modport slave (input scl, input sda, output sdaSOut, output sdaSOe);
  modport master (input scl, input sda, output sclOut, output sclOe,
                  output sdaMOut, output sdaMOe);
endinterface

/* verilog/dtts_slave.sv */
// Slave end: conditions, address decode, pointers, byte transfers
`timescale 1ns/1ps
module dtts_slave (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Bus
  dtts_bus_if.slave        bus,
  // Straps and supply
  input  wire logic [1:0]  selPins,
  input  wire logic        powerTrip,
  // User side
  output logic [14:0]      memAddr,
  output logic             memWe,
  output logic             memRe,
  output logic [7:0]       memWdata,
  input  wire logic [7:0]  memRdata,
  output logic [7:0]       regAddr,
  output logic             regWe,
  output logic             regRe,
  output logic [7:0]       regWdata,
  input  wire logic [7:0]  regRdata,
  output logic             busy
);
  typedef enum logic [2:0] {
    DTTS_IDLE = 3'b000, DTTS_DEVADDR = 3'b001, DTTS_ADDRHI = 3'b010,
    DTTS_ADDRLO = 3'b011, DTTS_WRITE = 3'b100, DTTS_READ = 3'b101,
    DTTS_ACKIN = 3'b110
  } dtts_state_e;

  logic [1:0] sclSync_q, sdaSync_q, pwrSync_q;
  logic [dtts_pkg::FILT_LEN-1:0] sclHist_q, sdaHist_q;
  logic       sclF_q, sdaF_q, sclPrev_q, sdaPrev_q;
  dtts_state_e state_q, state_d;
  logic [7:0] shift_q;
  logic [3:0] bitCnt_q;
  logic       ackPhase_q, isReg_q, rdDir_q, sdaDrv_q, nack_q;
  logic [14:0] memPtr_q;
  logic [7:0] regPtr_q;
  logic       memWe_q, memRe_q, regWe_q, regRe_q;
  logic [7:0] wdata_q;

  // Two-flop synchronisers for pins, then majority-free equal-run filter
  always_ff @(posedge clk_sys) begin
    sclSync_q <= {sclSync_q[0], bus.scl};
    sdaSync_q <= {sdaSync_q[0], bus.sda};
    pwrSync_q <= {pwrSync_q[0], powerTrip};
  end
  logic [1:0] selPinsSync_q, selMid_q;
  always_ff @(posedge clk_sys) begin
    selMid_q      <= selPins;
    selPinsSync_q <= selMid_q;
  end
  always_ff @(posedge clk_sys) begin
    sclHist_q <= {sclHist_q[dtts_pkg::FILT_LEN-2:0], sclSync_q[1]};
    sdaHist_q <= {sdaHist_q[dtts_pkg::FILT_LEN-2:0], sdaSync_q[1]};
  end

  // Filtered levels change only after a stable run (see R24)
  wire sclStable = (&sclHist_q) | ~(|sclHist_q);
  wire sdaStable = (&sdaHist_q) | ~(|sdaHist_q);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclF_q <= 1'b1; sdaF_q <= 1'b1; sclPrev_q <= 1'b1; sdaPrev_q <= 1'b1;
    end else begin
      if (sclStable) sclF_q <= sclHist_q[0];
      if (sdaStable) sdaF_q <= sdaHist_q[0];
      sclPrev_q <= sclF_q;
      sdaPrev_q <= sdaF_q;
    end
  end

  // Edge and condition detection
  wire sclRise   = sclF_q & ~sclPrev_q;
  wire sclFall   = ~sclF_q & sclPrev_q;
  wire startCond = sclF_q & sclPrev_q & sdaPrev_q & ~sdaF_q; // see R5
  wire stopCond  = sclF_q & sclPrev_q & ~sdaPrev_q & sdaF_q; // see R4
  wire tripped   = pwrSync_q[1];
  wire abortAll  = stopCond | tripped; // see R4 see R6

  // Byte and slot decode
  wire byteDone  = sclRise & ~ackPhase_q & (bitCnt_q == 4'(dtts_pkg::BIT_COUNT - 1));
  wire [7:0] rxByte = {shift_q[6:0], sdaF_q}; // see R20
  wire idHit     = (rxByte[7:4] == dtts_pkg::MEM_ID) | (rxByte[7:4] == dtts_pkg::REG_ID);
  wire selHit    = (rxByte[2:1] == selPinsSync_q); // see R11
  wire addrOk    = idHit & selHit; // see R1 see R2
  wire regAddrOk = (rxByte <= dtts_pkg::REG_ADDR_MAX); // see R17 see R18
  wire ackSample = sclRise & ackPhase_q;
  wire masterAck = ~sdaF_q; // see R9 see R10
  wire [7:0] rdByte = isReg_q ? regRdata : memRdata;

  // Next state on each completed byte or acknowledge slot
  always_comb begin
    state_d = state_q;
    case (state_q)
      DTTS_DEVADDR: if (byteDone) begin
        state_d = !addrOk ? DTTS_IDLE : rxByte[0] ? DTTS_READ : DTTS_ADDRHI; // see R12
      end
      DTTS_ADDRHI: if (byteDone) begin
        state_d = isReg_q ? (regAddrOk ? DTTS_WRITE : DTTS_IDLE) : DTTS_ADDRLO;
      end
      DTTS_ADDRLO: if (byteDone) state_d = DTTS_WRITE; // see R13
      DTTS_READ:   if (byteDone) state_d = DTTS_ACKIN;
      DTTS_ACKIN:  if (ackSample) state_d = masterAck ? DTTS_READ : DTTS_IDLE;
      default:     state_d = state_q;
    endcase
  end

  // Main sequencer; reset, stop and trip abort and win over start (see R3)
  always_ff @(posedge clk_sys) begin
    memWe_q <= 1'b0; memRe_q <= 1'b0; regWe_q <= 1'b0; regRe_q <= 1'b0;
    if (rst || abortAll) begin
      state_q <= DTTS_IDLE; bitCnt_q <= 4'h0; ackPhase_q <= 1'b0;
      sdaDrv_q <= 1'b0; nack_q <= 1'b0; shift_q <= 8'h00;
      if (rst) begin
        isReg_q <= 1'b0; rdDir_q <= 1'b0; wdata_q <= 8'h00;
      end
    end else if (startCond) begin
      state_q <= DTTS_DEVADDR; bitCnt_q <= 4'h0; ackPhase_q <= 1'b0; // see R5
      sdaDrv_q <= 1'b0; nack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (sclRise && !ackPhase_q && state_q != DTTS_IDLE) begin // see R7
        shift_q  <= rxByte;
        bitCnt_q <= bitCnt_q + 4'h1;
      end
      if (byteDone) begin // see R8 see R19
        ackPhase_q <= 1'b1;
        bitCnt_q   <= 4'h0;
        case (state_q)
          DTTS_DEVADDR: begin
            isReg_q <= (rxByte[7:4] == dtts_pkg::REG_ID);
            rdDir_q <= rxByte[0];
            nack_q  <= ~addrOk;
          end
          DTTS_ADDRHI: nack_q <= isReg_q & ~regAddrOk; // see R18
          DTTS_WRITE: begin
            wdata_q <= rxByte;
            memWe_q <= ~isReg_q; // see R23 see R2
            regWe_q <= isReg_q;
          end
          default: nack_q <= 1'b0;
        endcase
      end
      if (ackSample) ackPhase_q <= 1'b0;
      // Slave drives its ack, then releases; read bits on clock fall
      // First read bit comes from rdata, later ones from the shifting byte
      if (sclFall) begin
        if (ackPhase_q && (!rdDir_q || state_q == DTTS_READ)) sdaDrv_q <= ~nack_q;
        else if (state_q == DTTS_READ && !ackPhase_q && bitCnt_q == 4'h0) begin
          sdaDrv_q <= ~rdByte[7]; // see R20
        end else if (state_q == DTTS_READ && !ackPhase_q) begin
          sdaDrv_q <= ~shift_q[7]; // see R20
        end else sdaDrv_q <= 1'b0; // see R8
      end
      // Load read data on entry to a read byte
      if ((state_q == DTTS_DEVADDR && byteDone && rxByte[0] && addrOk) ||
          (state_q == DTTS_ACKIN && ackSample && masterAck)) begin // see R10 see R14
        memRe_q <= ~((state_q == DTTS_DEVADDR) ? (rxByte[7:4] == dtts_pkg::REG_ID) : isReg_q);
        regRe_q <= (state_q == DTTS_DEVADDR) ? (rxByte[7:4] == dtts_pkg::REG_ID) : isReg_q;
      end
      if (state_q == DTTS_READ && bitCnt_q == 4'h0 && !ackPhase_q && sclPrev_q && !sclF_q)
        shift_q <= rdByte;
    end
  end

  // Address pointers, independent per target (see R22)
  always_ff @(posedge clk_sys) begin
    if (rst || tripped) begin // see R14
      memPtr_q <= dtts_pkg::MEM_PTR_RST;
      regPtr_q <= dtts_pkg::REG_PTR_RST;
    end else if (!startCond && !stopCond && byteDone) begin
      if (state_q == DTTS_ADDRHI && !isReg_q) memPtr_q <= {rxByte[6:0], memPtr_q[7:0]};
      else if (state_q == DTTS_ADDRLO) memPtr_q <= {memPtr_q[14:8], rxByte}; // see R13
      else if (state_q == DTTS_ADDRHI && regAddrOk) regPtr_q <= rxByte; // see R17
      else if (state_q == DTTS_WRITE || state_q == DTTS_READ) begin // see R15 see R16
        if (isReg_q) regPtr_q <= regPtr_q + 8'h01;
        else memPtr_q <= memPtr_q + 15'h0001;
      end
    end
  end

  // Registered user-side outputs
  logic [14:0] memAddr_q;
  logic [7:0]  regAddr_q;
  logic        busy_q, sdaOe_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      memAddr_q <= 15'h0000; regAddr_q <= 8'h00; busy_q <= 1'b0; sdaOe_q <= 1'b1;
    end else begin
      memAddr_q <= memPtr_q;
      regAddr_q <= regPtr_q;
      busy_q    <= (state_q != DTTS_IDLE);
      sdaOe_q   <= ~sdaDrv_q;
    end
  end

  assign memAddr  = memAddr_q;
  assign regAddr  = regAddr_q;
  assign memWe    = memWe_q;
  assign regWe    = regWe_q;
  assign memRe    = memRe_q;
  assign regRe    = regRe_q;
  assign memWdata = wdata_q;
  assign regWdata = wdata_q;
  assign busy     = busy_q;
  assign bus.sdaSOut = 1'b0;
  assign bus.sdaSOe  = sdaOe_q;
endmodule

/* verilog/dtts_master.sv */
// Master end: generates the clock and runs one command per request
`timescale 1ns/1ps
module dtts_master #(
  parameter int HALF_CYC = dtts_pkg::SCL_HALF_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Bus
  dtts_bus_if.master       bus,
  // Command: send start (optional), a byte or read one, then stop (optional)
  input  wire logic        cmdValid,
  input  wire logic        cmdStart,
  input  wire logic        cmdStop,
  input  wire logic        cmdRead,
  input  wire logic        cmdAck,
  input  wire logic [7:0]  cmdData,
  output logic             cmdReady,
  output logic [7:0]       rspData,
  output logic             rspAckSeen,
  output logic             rspValid
);
  typedef enum logic [2:0] {
    DTTSM_IDLE = 3'b000, DTTSM_START = 3'b001, DTTSM_BIT = 3'b010,
    DTTSM_STOP = 3'b011, DTTSM_DONE = 3'b100
  } dttsm_state_e;

  dttsm_state_e state_q;
  logic [1:0]  sdaSync_q;
  logic [15:0] div_q;
  logic [1:0]  phase_q;
  logic [3:0]  bitIdx_q;
  logic [7:0]  tx_q, rx_q;
  logic        rd_q, ack_q, stop_q, sclLow_q, sdaLow_q, ackSeen_q, rspV_q;

  // Sample the bus line through two flops
  always_ff @(posedge clk_sys) sdaSync_q <= {sdaSync_q[0], bus.sda};

  wire tick = (div_q == 16'(HALF_CYC - 1));
  // Bit slot 8 is the acknowledge slot (see R8)
  wire ackSlot = (bitIdx_q == 4'h8);
  wire txBit   = ackSlot ? (rd_q ? ~ack_q : 1'b1) : (rd_q ? 1'b1 : tx_q[7 - bitIdx_q[2:0]]);

  // Master alone drives the clock (see R3); data bits change only while low (see R7), start and stop move data while high
  always_ff @(posedge clk_sys) begin
    rspV_q <= 1'b0;
    if (rst) begin
      state_q <= DTTSM_IDLE; div_q <= 16'h0000; phase_q <= 2'h0; bitIdx_q <= 4'h0;
      sclLow_q <= 1'b0; sdaLow_q <= 1'b0; tx_q <= 8'h00; rx_q <= 8'h00;
      rd_q <= 1'b0; ack_q <= 1'b0; stop_q <= 1'b0; ackSeen_q <= 1'b0;
    end else begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
      case (state_q)
        DTTSM_IDLE: if (cmdValid) begin
          tx_q <= cmdData; rd_q <= cmdRead; ack_q <= cmdAck; stop_q <= cmdStop;
          bitIdx_q <= 4'h0; phase_q <= 2'h0; div_q <= 16'h0000;
          state_q <= cmdStart ? DTTSM_START : DTTSM_BIT;
        end
        DTTSM_START: if (tick) begin // see R5
          phase_q <= phase_q + 2'h1;
          if (phase_q == 2'h0) begin sclLow_q <= 1'b0; sdaLow_q <= 1'b0; end
          else if (phase_q == 2'h1) sdaLow_q <= 1'b1;
          else begin sclLow_q <= 1'b1; phase_q <= 2'h0; state_q <= DTTSM_BIT; end
        end
        DTTSM_BIT: if (tick) begin // see R20
          phase_q <= phase_q + 2'h1;
          if (phase_q == 2'h0) sdaLow_q <= ~txBit;
          else if (phase_q == 2'h1) sclLow_q <= 1'b0;
          else begin
            if (ackSlot) ackSeen_q <= ~sdaSync_q[1]; // see R9
            else rx_q <= {rx_q[6:0], sdaSync_q[1]};
            sclLow_q <= 1'b1; phase_q <= 2'h0;
            if (ackSlot) state_q <= stop_q ? DTTSM_STOP : DTTSM_DONE; // see R10
            else bitIdx_q <= bitIdx_q + 4'h1;
          end
        end
        DTTSM_STOP: if (tick) begin // see R4
          phase_q <= phase_q + 2'h1;
          if (phase_q == 2'h0) sdaLow_q <= 1'b1;
          else if (phase_q == 2'h1) sclLow_q <= 1'b0;
          else begin sdaLow_q <= 1'b0; phase_q <= 2'h0; state_q <= DTTSM_DONE; end
        end
        default: begin rspV_q <= 1'b1; state_q <= DTTSM_IDLE; end
      endcase
    end
  end

  // Registered outputs; enables low while pulling low
  logic ready_q, sclOe_q, sdaOe_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin ready_q <= 1'b0; sclOe_q <= 1'b1; sdaOe_q <= 1'b1; end
    else begin
      ready_q <= (state_q == DTTSM_IDLE) && !cmdValid;
      sclOe_q <= ~sclLow_q;
      sdaOe_q <= ~sdaLow_q;
    end
  end

  assign cmdReady    = ready_q;
  assign rspData     = rx_q;
  assign rspAckSeen  = ackSeen_q;
  assign rspValid    = rspV_q;
  assign bus.sclOut  = 1'b0;
  assign bus.sclOe   = sclOe_q;
  assign bus.sdaMOut = 1'b0;
  assign bus.sdaMOe  = sdaOe_q;
endmodule

/* test/dtts_link_assertions.sv */
// Protocol checks on the two-wire link between slave and master ends
`timescale 1ns/1ps
module dtts_link_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bus lines and enables
  input wire logic scl,
  input wire logic sda,
  input wire logic sclOe,
  input wire logic sdaSOe
);
  logic       sclQ, sdaQ, quietQ;
  logic [3:0] bitQ;
  logic [1:0] byteQ;
  logic [7:0] shQ, firstQ;
  // Bus conditions seen on the resolved lines
  wire rise   = scl && !sclQ;
  wire start  = scl && sclQ && sdaQ && !sda;
  wire stop   = scl && sclQ && !sdaQ && sda;
  wire rdData = (byteQ != 2'h0) && firstQ[0];
  // Bit and byte tracking; quiet after stop or no-acknowledge
  always_ff @(posedge clk_sys) begin
    sclQ <= rst | scl;
    sdaQ <= rst | sda;
    quietQ <= rst | stop | (!start & (quietQ | (rise & bitQ == 4'h8 & sda)));
    if (rst || start) begin
      bitQ <= 4'h0;
      byteQ <= 2'h0;
    end else if (rise) begin
      bitQ <= (bitQ == 4'h8) ? 4'h0 : bitQ + 4'h1;
      if (bitQ == 4'h8 && byteQ != 2'h3) byteQ <= byteQ + 2'h1;
      if (bitQ != 4'h8) shQ <= {shQ[6:0], sda};
      if (bitQ == 4'h8 && byteQ == 2'h0) firstQ <= shQ;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_ackSlot;
    rise && bitQ == 4'h8;
  endsequence
  property p_sclMaster;
    rise |-> scl [*8];
  endproperty
  property p_stableHigh;
    scl && $past(scl) |-> $stable(sdaSOe);
  endproperty
  property p_quiet;
    quietQ |-> sdaSOe;
  endproperty
  property p_startRelease;
    start |-> ##[0:8] sdaSOe;
  endproperty
  property p_writeAckOnly;
    rise && bitQ != 4'h8 && !rdData |-> sdaSOe;
  endproperty
  property p_readAckReleased;
    s_ackSlot ##0 rdData |-> sdaSOe;
  endproperty
  property p_badId;
    s_ackSlot ##0 (byteQ == 2'h0 && shQ[7:4] != dtts_pkg::MEM_ID
      && shQ[7:4] != dtts_pkg::REG_ID) |-> sda;
  endproperty
  property p_regRange;
    s_ackSlot ##0 (byteQ == 2'h1 && firstQ[7:4] == dtts_pkg::REG_ID && !firstQ[0]
      && shQ > dtts_pkg::REG_ADDR_MAX) |-> sda;
  endproperty
  a_sclMaster: assert property (p_sclMaster) else $error("clock high phase too short");
  a_stableHigh: assert property (p_stableHigh) else $error("slave moved data in high");
  a_quiet: assert property (p_quiet) else $error("slave drove after stop or nack");
  a_startRelease: assert property (p_startRelease) else $error("start not released");
  a_writeAckOnly: assert property (p_writeAckOnly) else $error("slave drove data bit");
  a_readAckReleased: assert property (p_readAckReleased) else $error("slave in ack");
  a_badId: assert property (p_badId) else $error("foreign id acknowledged");
  a_regRange: assert property (p_regRange) else $error("bad register acknowledged");
endmodule

/* test/test_dual_target_two_wire_slave.sv */
// Bench joining slave and master ends over the shared two-wire bus
`timescale 1ns/1ps
module test_dual_target_two_wire_slave;
  logic        clk_sys, rst, powerTrip, memWe, memRe, regWe, regRe, busy, ak;
  logic        cmdValid, cmdStart, cmdStop, cmdRead, cmdAck, cmdReady, rspAckSeen, rspValid;
  logic [1:0]  selPins;
  logic [14:0] memAddr, ptr;
  logic [7:0]  memWdata, memRdata, regAddr, regWdata, regRdata, cmdData, rspData, rd;
  logic [22:0] memQ[$];
  logic [15:0] regQ[$];
  logic [3:0]  idTab [4] = '{4'ha, 4'ha, 4'hb, 4'hd};
  logic [1:0]  selTab [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
  integer      seed;
  int          err_count, compares;
  int          memRdCnt, regRdCnt;
  // Design ends, bus and link checker
  dtts_bus_if u_dtts_bus_if ();
  dtts_slave u_dtts_slave (.clk_sys(clk_sys), .rst(rst), .bus(u_dtts_bus_if),
    .selPins(selPins), .powerTrip(powerTrip), .memAddr(memAddr), .memWe(memWe),
    .memRe(memRe), .memWdata(memWdata), .memRdata(memRdata), .regAddr(regAddr),
    .regWe(regWe), .regRe(regRe), .regWdata(regWdata), .regRdata(regRdata), .busy(busy));
  dtts_master #(.HALF_CYC(20)) u_dtts_master (.clk_sys(clk_sys), .rst(rst),
    .bus(u_dtts_bus_if), .cmdValid(cmdValid), .cmdStart(cmdStart), .cmdStop(cmdStop),
    .cmdRead(cmdRead), .cmdAck(cmdAck), .cmdData(cmdData), .cmdReady(cmdReady),
    .rspData(rspData), .rspAckSeen(rspAckSeen), .rspValid(rspValid));
  dtts_link_assertions chk (.clk_sys(clk_sys), .rst(rst), .scl(u_dtts_bus_if.scl),
    .sda(u_dtts_bus_if.sda), .sclOe(u_dtts_bus_if.sclOe), .sdaSOe(u_dtts_bus_if.sdaSOe));
  // Read stubs answer with a pattern of the pointer
  function automatic logic [7:0] memPat(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5a;
  endfunction
  function automatic logic [7:0] dev(input logic [3:0] id, input logic rw);
    return {id, 1'b0, selPins, rw};
  endfunction
  assign memRdata = memPat(memAddr);
  assign regRdata = regAddr ^ 8'hc3;
  always #5 clk_sys = ~clk_sys;
  // Record every write strobe on the user side
  always @(posedge clk_sys) begin
    if (memWe === 1'b1) memQ.push_back({memAddr, memWdata});
    if (regWe === 1'b1) regQ.push_back({regAddr, regWdata});
    if (memRe === 1'b1) memRdCnt++;
    if (regRe === 1'b1) regRdCnt++;
  end
  task automatic check(input string name, input logic [22:0] seen, input logic [22:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge clk_sys);
    #1;
    n++;
    if (n > 4000) begin
      err_count++;
      complete_run();
    end
  endtask
  // One master command: wait ready, hold until taken, collect response
  task automatic cmd(input logic s, input logic p, input logic r, input logic a,
                     input logic [7:0] d);
    int n;
    n = 0;
    while (cmdReady !== 1'b1) tick(n);
    cmdValid = 1'b1;
    {cmdStart, cmdStop, cmdRead, cmdAck, cmdData} = {s, p, r, a, d};
    tick(n);
    cmdValid = 1'b0;
    while (rspValid !== 1'b1) tick(n);
    rd = rspData;
    ak = rspAckSeen;
  endtask
  task automatic set_mem_ptr(input logic [14:0] a);
    cmd(1'b1, 1'b0, 1'b0, 1'b0, dev(4'ha, 1'b0));
    check("dev ack", ak, 1'b1);
    cmd(1'b0, 1'b0, 1'b0, 1'b0, {a[0] ^ a[9], a[14:8]});
    check("addr hi ack", ak, 1'b1);
    cmd(1'b0, 1'b0, 1'b0, 1'b0, a[7:0]);
    check("addr lo ack", ak, 1'b1);
    check("busy open", busy, 1'b1);
    ptr = a;
  endtask
  task automatic mem_write(input logic [14:0] a, input int n);
    logic [7:0] d;
    set_mem_ptr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      cmd(1'b0, i == n - 1, 1'b0, 1'b0, d);
      check("data ack", ak, 1'b1);
      check("mem write", memQ.size() ? memQ.pop_front() : '1, {ptr, d});
      ptr = ptr + 15'h1;
    end
  endtask
  task automatic mem_read(input int n);
    int base;
    base = memRdCnt;
    cmd(1'b1, 1'b0, 1'b0, 1'b0, dev(4'ha, 1'b1));
    check("read dev ack", ak, 1'b1);
    for (int i = 0; i < n; i++) begin
      cmd(1'b0, i == n - 1, 1'b1, i != n - 1, 8'h00);
      check("mem read", rd, memPat(ptr));
      ptr = ptr + 15'h1;
    end
    check("mem read strobes", memRdCnt - base, n);
  endtask
  task automatic reg_op(input logic [7:0] ra, input logic [7:0] d);
    int base;
    base = regRdCnt;
    cmd(1'b1, 1'b0, 1'b0, 1'b0, dev(4'hd, 1'b0));
    check("reg dev ack", ak, 1'b1);
    cmd(1'b0, 1'b0, 1'b0, 1'b0, ra);
    check("reg addr ack", ak, ra <= dtts_pkg::REG_ADDR_MAX);
    if (ra < dtts_pkg::REG_ADDR_MAX) begin
      cmd(1'b0, 1'b1, 1'b0, 1'b0, d);
      check("reg write", regQ.size() ? regQ.pop_front() : '1, {ra, d});
      check("no mem write", memQ.size(), 0);
      cmd(1'b1, 1'b0, 1'b0, 1'b0, dev(4'hd, 1'b1));
      cmd(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
      check("reg read", rd, (ra + 8'h1) ^ 8'hc3);
      check("reg read strobes", regRdCnt - base, 1);
    end
  endtask
  // Main sequence
  initial begin
    seed = 55402;
    err_count = 0;
    compares = 0;
    memRdCnt = 0;
    regRdCnt = 0;
    clk_sys = 1'b0;
    rst = 1'b1;
    powerTrip = 1'b0;
    selPins = 2'($random(seed));
    cmdValid = 1'b0;
    {cmdStart, cmdStop, cmdRead, cmdAck, cmdData} = '0;
    repeat (3) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    for (int k = 0; k < 4; k++) begin
      cmd(1'b1, 1'b0, 1'b0, 1'b0, {idTab[k], 1'b0, selPins ^ selTab[k], 1'b0});
      check("select ack", ak, k == 0);
    end
    mem_write(15'h7ffe, 3);
    repeat (30) @(posedge clk_sys);
    #1;
    check("busy after stop", busy, 1'b0);
    for (int k = 0; k < 3; k++) mem_write(15'($random(seed)), 1 + 2 * k);
    set_mem_ptr(15'h7fff);
    mem_read(3);
    mem_read(1);
    reg_op(8'h05, 8'($random(seed)));
    mem_read(1);
    reg_op(8'h18, 8'h00);
    reg_op(8'h19, 8'h00);
    reg_op(8'hff, 8'h00);
    set_mem_ptr(15'($random(seed)));
    powerTrip = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1;
    check("trip busy", busy, 1'b0);
    check("trip pointers", {memAddr, regAddr}, 23'h0);
    powerTrip = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    ptr = 15'h0;
    mem_read(2);
    complete_run();
  end
endmodule
